//--- inc/hdlc_rx_defines.svh
// named constants for the receive frame handler and clock selector
`ifndef HDLC_RX_DEFINES_SVH
`define HDLC_RX_DEFINES_SVH
`define ADDR_FIXED_A 8'hfe
`define ADDR_FIXED_B 8'hfc
`define CR_BIT_MASK 8'hfd
`define CTRL_S_FRAME 2'h1
`define BUF_BYTES 64
`define POOL_BYTES 32
`define MAX_FRAMES 2'h2
`define BRG_PRESCALE 4'hf
`define RAW_LAST 3'h7
`define CLK_MODE_SEP 3'h0
`define CLK_MODE_SHARED 3'h1
`define CMD_RX_RELEASE 0
`define CMD_PWR_UP 1
`define CMD_PWR_DOWN 2
`define CMD_W 3
`endif

//--- inc/hdlc_rx_pkg.sv
// types shared by the receive frame handler
package hdlc_rx_pkg;
  typedef enum logic [2:0] {
    MODE_AUTO = 3'h0,
    MODE_NONAUTO = 3'h1,
    MODE_TRANSP = 3'h2,
    MODE_EXT0 = 3'h3,
    MODE_EXT1 = 3'h4
  } rx_mode_type;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR_H = 6'h02,
    ST_ADDR_L = 6'h04,
    ST_CTRL = 6'h08,
    ST_DATA = 6'h10,
    ST_DROP = 6'h20
  } rx_state_type;
  typedef enum logic [1:0] {
    RXS_PIN = 2'h0,
    RXS_DPLL = 2'h1,
    RXS_OSC = 2'h2
  } rx_src_type;
  typedef enum logic [2:0] {
    TXS_RXPIN = 3'h0,
    TXS_TXPIN = 3'h1,
    TXS_DPLL = 3'h2,
    TXS_BRG16 = 3'h3,
    TXS_OSC = 3'h4
  } tx_src_type;
endpackage

//--- src/hdlc_rx_channel.sv
// hdlc receive frame handler with clock selection and status chaining
`timescale 1ns/1ps
`include "hdlc_rx_defines.svh"
// Summary of operation
// - primary status chains channel and extended flags
// - five per-channel frame handling modes
// - auto mode handles numbered frames of link
// - high byte matches fe, fc, programmed value
// - low byte matches two values, six combinations
// - only first high/low pair auto processed
// - one-byte address: command or response match
// - non-auto forwards valid; two frames held
// - transparent compares high, exposes low, control
// - transparent one-byte stores every frame
// - extended mode 0 stores whole frame
// - extended 1 bypass: raw byte each eight
// - extended 1 active compares first byte
// - receive and transmit clock source select
// - baud generator feeds dpll, divide 1..2048
// - power-down stops clocks, entered at reset
// - clock mode 0 separate pin clocks
// - clock mode 1 shared clock, optional strobes
// - transmit clock pin direction, component clock
// - status readable, commands by register write
// - 64-byte buffer, event per 32-byte pool
module hdlc_rx_channel
  import hdlc_rx_pkg::*;
#(
  parameter int BUF_DEPTH = `BUF_BYTES,
  parameter int POOL_SIZE = `POOL_BYTES,
  parameter int BRG_W = 11
) (
  // clock and reset
  input logic clk_sys_i,
  input logic rst_n_i,
  // frame mode and address compare values
  input rx_mode_type rx_mode_i,
  input logic addr2_i,
  input logic rx_enable_i,
  input logic cr_bit_interpret_i,
  input logic [7:0] high_addr_cmp_1_i,
  input logic [7:0] high_addr_cmp_2_i,
  input logic [7:0] low_addr_cmp_1_i,
  input logic [7:0] low_addr_cmp_2_i,
  // clock multiplexer configuration
  input logic [2:0] clk_mode_i,
  input rx_src_type rx_src_i,
  input tx_src_type tx_src_i,
  input logic strobe_en_i,
  input logic tio_i,
  input logic [BRG_W-1:0] baud_divider_i,
  // command register write
  input logic cmd_wr_i,
  input logic [`CMD_W-1:0] command_reg_i,
  // deframed receive byte stream
  input logic frm_start_i,
  input logic byte_vld_i,
  input logic [7:0] byte_i,
  input logic frm_end_i,
  input logic crc_ok_i,
  // serial side pins
  input logic rxclk_pin_i,
  input logic txclk_pin_i,
  input logic osc_pin_i,
  input logic strobe_pin_i,
  input logic rxd_pin_i,
  // other channel interrupt flags
  input logic ext_irq_b_i,
  input logic ext_irq_a_i,
  input logic prim_irq_a_i,
  // host read side
  input logic irq_rd_i,
  input logic buf_rd_i,
  output logic [7:0] buf_data_o,
  output logic [7:0] primary_irq_status_o,
  output logic [7:0] channel_status_o,
  output logic [7:0] rx_frame_status_o,
  output logic [7:0] rx_control_field_o,
  output logic [7:0] rx_addr_low_o,
  // events
  output logic rx_frame_evt_o,
  output logic pool_full_evt_o,
  output logic auto_ack_o,
  // clock outputs
  output logic rx_tick_o,
  output logic tx_tick_o,
  output logic dpll_tick_o,
  output logic txclk_o,
  output logic txclk_oe_o,
  output logic osc_en_o
);
  localparam int AW = $clog2(BUF_DEPTH);
  localparam int PW = $clog2(POOL_SIZE);

  function automatic logic hi_eq(input logic [7:0] b, input logic [7:0] c);
    hi_eq = (b & `CR_BIT_MASK) == (c & `CR_BIT_MASK);
  endfunction

  logic [4:0] sync1_q, sync2_q, prev_q, edge_t;
  logic [BRG_W-1:0] brg_cnt_q;
  logic [3:0] pre16_q;
  logic pd_q, brg_t, brg16_t, rx_t, tx_t, txclk_q, rx_tick_q, tx_tick_q;
  rx_state_type st_q, st_d;
  logic store, wr_en, rd_en, rx_off, acc, fwd, hi_hit, lo1, lo2;
  logic is_ext0, is_ext1, is_transp, is_auto, raw_mode, raw_load;
  logic link_q, cr_q, auto_s_q, i_frm_q, vr_q, ovf_q, rfp_q, rpf_q;
  logic [7:0] mem_q [0:BUF_DEPTH-1];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic [1:0] frame_cnt_q;
  logic [7:0] raw_sh_q, raw_next, addr_low_q, ctrl_q, buf_data_q;
  logic [7:0] prim_q, chan_q, fstat_q;
  logic [2:0] raw_cnt_q;
  logic frame_evt_q, pool_evt_q, ack_q;

  // two-flop synchronisers and edge memory for all pins
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      prev_q <= 5'h00;
    end else begin
      sync1_q <= {rxd_pin_i, strobe_pin_i, osc_pin_i, txclk_pin_i,
                  rxclk_pin_i};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  assign edge_t = sync2_q & ~prev_q;

  // baud generator on oscillator, divide by divider+1, dpll reference
  assign brg_t = edge_t[2] & ~pd_q & (brg_cnt_q == baud_divider_i);
  assign brg16_t = brg_t & (pre16_q == `BRG_PRESCALE);
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      brg_cnt_q <= '0;
      pre16_q <= 4'h0;
    end else if (edge_t[2] && !pd_q) begin
      brg_cnt_q <= brg_t ? '0 : brg_cnt_q + 1'b1;
      pre16_q <= brg_t ? pre16_q + 4'h1 : pre16_q;
    end
  end

  // clock source selection, gated off in power-down
  always_comb begin
    rx_t = 1'b0;
    tx_t = 1'b0;
    if (clk_mode_i == `CLK_MODE_SEP) begin
      rx_t = edge_t[0];
      tx_t = edge_t[1];
    end else if (clk_mode_i == `CLK_MODE_SHARED) begin
      rx_t = edge_t[0] & (~strobe_en_i | sync2_q[3]);
      tx_t = edge_t[0] & (~strobe_en_i | sync2_q[3]);
    end else begin
      case (rx_src_i)
        RXS_PIN: rx_t = edge_t[0];
        RXS_DPLL: rx_t = brg_t;
        RXS_OSC: rx_t = edge_t[2];
        default: rx_t = 1'b0;
      endcase
      case (tx_src_i)
        TXS_RXPIN: tx_t = edge_t[0];
        TXS_TXPIN: tx_t = edge_t[1];
        TXS_DPLL: tx_t = brg_t;
        TXS_BRG16: tx_t = brg16_t;
        TXS_OSC: tx_t = edge_t[2];
        default: tx_t = 1'b0;
      endcase
    end
    if (pd_q) begin
      rx_t = 1'b0;
      tx_t = 1'b0;
    end
  end

  // power-down flag set by reset, changed by commands
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) pd_q <= 1'b1;
    else if (cmd_wr_i && command_reg_i[`CMD_PWR_DOWN]) pd_q <= 1'b1;
    else if (cmd_wr_i && command_reg_i[`CMD_PWR_UP]) pd_q <= 1'b0;
  end

  // registered clock ticks and transmit pin drive
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_tick_q <= 1'b0;
      tx_tick_q <= 1'b0;
      txclk_q <= 1'b0;
    end else begin
      rx_tick_q <= rx_t;
      tx_tick_q <= tx_t;
      txclk_q <= txclk_q ^ tx_t;
    end
  end
  assign txclk_oe_o = tio_i & (clk_mode_i > `CLK_MODE_SHARED);

  // mode decode and address comparison
  assign is_ext0 = rx_mode_i == MODE_EXT0;
  assign is_ext1 = rx_mode_i == MODE_EXT1;
  assign is_transp = rx_mode_i == MODE_TRANSP;
  assign is_auto = rx_mode_i == MODE_AUTO;
  assign rx_off = ~rx_enable_i;
  assign hi_hit = hi_eq(byte_i, `ADDR_FIXED_A) | hi_eq(byte_i, `ADDR_FIXED_B)
                | hi_eq(byte_i, high_addr_cmp_1_i)
                | (is_ext1 & hi_eq(byte_i, high_addr_cmp_2_i));
  assign lo1 = byte_i == low_addr_cmp_1_i;
  assign lo2 = byte_i == low_addr_cmp_2_i;

  // frame walk: decide next state and which bytes are stored
  always_comb begin
    st_d = st_q;
    store = 1'b0;
    case (st_q)
      ST_IDLE, ST_DROP: st_d = st_q;
      ST_ADDR_H: if (byte_vld_i) begin
        case (rx_mode_i)
          MODE_EXT0: begin
            st_d = ST_CTRL;
            store = 1'b1;
          end
          MODE_EXT1: st_d = hi_hit ? ST_DATA : ST_DROP;
          MODE_TRANSP: st_d = !addr2_i ? ST_CTRL :
                              hi_hit ? ST_ADDR_L : ST_DROP;
          default: st_d = addr2_i ? (hi_hit ? ST_ADDR_L : ST_DROP)
                          : ((lo1 | lo2) ? ST_CTRL : ST_DROP);
        endcase
      end
      ST_ADDR_L: if (byte_vld_i) begin
        st_d = (is_transp | lo1 | lo2) ? ST_CTRL : ST_DROP;
      end
      ST_CTRL: if (byte_vld_i) begin
        st_d = ST_DATA;
        store = is_ext0;
      end
      ST_DATA: store = byte_vld_i & ~auto_s_q;
      default: st_d = ST_IDLE;
    endcase
    if (frm_end_i) st_d = ST_IDLE;
    if (frm_start_i) st_d = (frame_cnt_q < `MAX_FRAMES) ? ST_ADDR_H : ST_DROP;
    if (rx_off) st_d = ST_IDLE;
  end
  assign wr_en = store & (cnt_q != (AW+1)'(BUF_DEPTH));
  assign rd_en = buf_rd_i & (cnt_q != '0);
  assign acc = frm_end_i & ((st_q == ST_CTRL) | (st_q == ST_DATA));
  assign fwd = acc & ~auto_s_q;

  // state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) st_q <= ST_IDLE;
    else st_q <= st_d;
  end

  // link, command/response and auto-mode frame type tracking
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_q <= 1'b0;
      cr_q <= 1'b0;
      auto_s_q <= 1'b0;
      i_frm_q <= 1'b0;
    end else if (frm_start_i) begin
      auto_s_q <= 1'b0;
      i_frm_q <= 1'b0;
    end else if (byte_vld_i && st_q == ST_ADDR_H) begin
      link_q <= addr2_i ? hi_eq(byte_i, high_addr_cmp_1_i) : lo1;
      cr_q <= addr2_i ? byte_i[1] ^ cr_bit_interpret_i : lo2;
    end else if (byte_vld_i && st_q == ST_ADDR_L) begin
      link_q <= link_q & lo1;
    end else if (byte_vld_i && st_q == ST_CTRL) begin
      auto_s_q <= is_auto & link_q & (byte_i[1:0] == `CTRL_S_FRAME);
      i_frm_q <= is_auto & link_q & ~byte_i[0];
    end
  end

  // low address, control field and raw bypass capture
  assign raw_mode = is_ext1 & rx_off;
  assign raw_next = {raw_sh_q[6:0], sync2_q[4]};
  assign raw_load = raw_mode & rx_t & (raw_cnt_q == `RAW_LAST);
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_sh_q <= 8'h00;
      raw_cnt_q <= 3'h0;
      addr_low_q <= 8'h00;
      ctrl_q <= 8'h00;
    end else begin
      if (raw_mode && rx_t) begin
        raw_sh_q <= raw_next;
        raw_cnt_q <= raw_cnt_q + 3'h1;
      end
      if (raw_load) addr_low_q <= raw_next;
      else if (byte_vld_i && (st_q == ST_ADDR_L || (st_q == ST_ADDR_H
               && (!addr2_i || is_ext0)))) addr_low_q <= byte_i;
      if (byte_vld_i && st_q == ST_CTRL) ctrl_q <= byte_i;
    end
  end

  // receive buffer of two pools with frame accounting
  always_ff @(posedge clk_sys_i) begin
    if (wr_en) mem_q[wp_q] <= byte_i;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      buf_data_q <= 8'h00;
      frame_cnt_q <= 2'h0;
      ovf_q <= 1'b0;
    end else begin
      wp_q <= wp_q + AW'(wr_en);
      rp_q <= rp_q + AW'(rd_en);
      cnt_q <= cnt_q + (AW+1)'(wr_en) - (AW+1)'(rd_en);
      if (rd_en) buf_data_q <= mem_q[rp_q];
      frame_cnt_q <= frame_cnt_q + 2'(fwd) - 2'(cmd_wr_i && frame_cnt_q
                     != 2'h0 && command_reg_i[`CMD_RX_RELEASE]);
      ovf_q <= (store & ~wr_en) | (ovf_q & ~fwd);
    end
  end

  // events, auto acknowledge and window-1 receive sequence
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_evt_q <= 1'b0;
      pool_evt_q <= 1'b0;
      ack_q <= 1'b0;
      vr_q <= 1'b0;
      fstat_q <= 8'h00;
    end else begin
      frame_evt_q <= fwd;
      pool_evt_q <= wr_en & (wp_q[PW-1:0] == PW'(POOL_SIZE-1));
      ack_q <= acc & i_frm_q & crc_ok_i;
      if (acc && i_frm_q && crc_ok_i) vr_q <= ~vr_q;
      if (fwd) fstat_q <= {4'h0, ovf_q, link_q, cr_q, crc_ok_i};
    end
  end

  // sticky status chaining and readable channel state
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rfp_q <= 1'b0;
      rpf_q <= 1'b0;
      prim_q <= 8'h00;
      chan_q <= 8'h00;
    end else begin
      rfp_q <= frame_evt_q | (rfp_q & ~irq_rd_i);
      rpf_q <= pool_evt_q | (rpf_q & ~irq_rd_i);
      prim_q <= {3'h0, rpf_q, rfp_q, prim_irq_a_i, ext_irq_a_i,
                 ext_irq_b_i};
      chan_q <= {3'h0, pd_q, vr_q, ovf_q, frame_cnt_q};
    end
  end

  assign buf_data_o = buf_data_q;
  assign primary_irq_status_o = prim_q;
  assign channel_status_o = chan_q;
  assign rx_frame_status_o = fstat_q;
  assign rx_control_field_o = ctrl_q;
  assign rx_addr_low_o = addr_low_q;
  assign rx_frame_evt_o = frame_evt_q;
  assign pool_full_evt_o = pool_evt_q;
  assign auto_ack_o = ack_q;
  assign rx_tick_o = rx_tick_q;
  assign tx_tick_o = tx_tick_q;
  assign dpll_tick_o = brg_t;
  assign txclk_o = txclk_q;
  assign osc_en_o = ~pd_q;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  chk_prim_chain: assert property (##1 primary_irq_status_o[2:0] ==
    $past({prim_irq_a_i, ext_irq_a_i, ext_irq_b_i}))
    else $error("primary status chain wrong");
  chk_drop_noevt: assert property (st_q == ST_DROP |=> !rx_frame_evt_o)
    else $error("dropped frame raised event");
  chk_drop_nowr: assert property (st_q == ST_DROP |-> !wr_en)
    else $error("dropped frame written");
  chk_pd_quiet: assert property (pd_q |=> !rx_tick_o && !tx_tick_o)
    else $error("clock runs in power-down");
  chk_mode0_rx: assert property (clk_mode_i == `CLK_MODE_SEP && !pd_q
    |-> rx_t == edge_t[0]) else $error("mode 0 rx clock wrong");
  chk_frame_limit: assert property (frame_cnt_q <= `MAX_FRAMES)
    else $error("more than two frames held");
  chk_buf_cap: assert property (cnt_q <= (AW+1)'(BUF_DEPTH))
    else $error("buffer over capacity");
  chk_raw_byte: assert property (raw_load |=> rx_addr_low_o ==
    $past(raw_next)) else $error("raw byte not captured");
  chk_auto_s: assert property (acc && auto_s_q |=> !rx_frame_evt_o)
    else $error("supervisory frame forwarded");
  chk_transp_one: assert property (is_transp && !addr2_i && !rx_off
    && st_q == ST_ADDR_H && byte_vld_i && !frm_start_i && !frm_end_i
    |=> st_q == ST_CTRL) else $error("transparent frame not kept");
endmodule

//--- sim/serial_line_model.sv
// serial side model: deframed byte stream and receive clock pin
`timescale 1ns/1ps
module serial_line_model (
  // clock
  input wire logic clk_sys_i,
  // deframed stream toward the channel
  output logic frm_start_o,
  output logic byte_vld_o,
  output logic [7:0] byte_o,
  output logic frm_end_o,
  output logic crc_ok_o,
  // receive clock pin
  output logic rxclk_pin_o
);
  logic [7:0] frame_mem [40];
  logic [7:0] last_q;
  // idle line at time zero
  initial begin
    frm_start_o = 1'b0;
    byte_vld_o = 1'b0;
    byte_o = 8'h00;
    frm_end_o = 1'b0;
    crc_ok_o = 1'b0;
    rxclk_pin_o = 1'b0;
    last_q = 8'h00;
  end
  // opening flag, n bytes back to back, closing flag
  task automatic send_frame(input int n, input logic crc);
    @(posedge clk_sys_i);
    #1 frm_start_o = 1'b1;
    @(posedge clk_sys_i);
    #1 frm_start_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      byte_vld_o = 1'b1;
      byte_o = frame_mem[i];
      last_q = frame_mem[i];
      @(posedge clk_sys_i);
      #1;
    end
    byte_vld_o = 1'b0;
    byte_o = ~last_q; // released line shows no stale byte
    frm_end_o = 1'b1;
    crc_ok_o = crc;
    @(posedge clk_sys_i);
    #1 frm_end_o = 1'b0;
    crc_ok_o = ~crc;
  endtask
  // pin clock runs only on request, eight system cycles a period
  task automatic run_clock(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      repeat (4) @(posedge clk_sys_i);
      #1 rxclk_pin_o = ~rxclk_pin_o; // slow clock keeps ratio small
    end
  endtask
endmodule

//--- sim/tb_top.sv
// self-checking bench for the receive frame handler
`timescale 1ns/1ps
module tb_top;
  import hdlc_rx_pkg::*;
  logic clk_sys_i, rst_n_i, addr2, rx_en, cmd_wr, irq_rd, buf_rd;
  logic ext_b, ext_a, prim_a, fs, bv, fe, crc, rxpin, evt, seen;
  rx_mode_type mode;
  logic [7:0] hc1, bt, buf_data, prim, chst, fst, ctrl, alow;
  logic [2:0] cmd;
  logic rtick;
  logic cr_inv, strb_en, strb, ack, ttick, pool, ack_got;
  logic [7:0] hc2, lc1, lc2;
  logic [2:0] cmode;
  rx_src_type rxsrc;
  int bad_count, comparisons, cycles, pools;
  // clock and watchdog
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  // pool events counted just after each edge
  always @(posedge clk_sys_i) begin
    #1;
    if (pool === 1'b1) pools++;
  end
  hdlc_rx_channel hdlc_rx_channel_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rx_mode_i(mode),
    .addr2_i(addr2), .rx_enable_i(rx_en), .cr_bit_interpret_i(cr_inv),
    .high_addr_cmp_1_i(hc1), .high_addr_cmp_2_i(hc2),
    .low_addr_cmp_1_i(lc1), .low_addr_cmp_2_i(lc2),
    .clk_mode_i(cmode), .rx_src_i(rxsrc), .tx_src_i(TXS_TXPIN),
    .strobe_en_i(strb_en), .tio_i(1'b0), .baud_divider_i(11'h003),
    .cmd_wr_i(cmd_wr), .command_reg_i(cmd), .frm_start_i(fs),
    .byte_vld_i(bv), .byte_i(bt), .frm_end_i(fe), .crc_ok_i(crc),
    .rxclk_pin_i(rxpin), .txclk_pin_i(1'b0), .osc_pin_i(rxpin),
    .strobe_pin_i(strb), .rxd_pin_i(rxpin), .ext_irq_b_i(ext_b),
    .ext_irq_a_i(ext_a), .prim_irq_a_i(prim_a), .irq_rd_i(irq_rd),
    .buf_rd_i(buf_rd), .buf_data_o(buf_data),
    .primary_irq_status_o(prim), .channel_status_o(chst),
    .rx_frame_status_o(fst), .rx_control_field_o(ctrl),
    .rx_addr_low_o(alow), .rx_frame_evt_o(evt), .pool_full_evt_o(pool),
    .auto_ack_o(ack), .rx_tick_o(rtick), .tx_tick_o(ttick), .dpll_tick_o(),
    .txclk_o(), .txclk_oe_o(), .osc_en_o(seen));
  serial_line_model serial_line_model_inst (
    .clk_sys_i(clk_sys_i), .frm_start_o(fs), .byte_vld_o(bv),
    .byte_o(bt), .frm_end_o(fe), .crc_ok_o(crc), .rxclk_pin_o(rxpin));
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] got,
                       input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic command(input logic [2:0] c);
    cmd_wr = 1'b1;
    cmd = c;
    tick();
    cmd_wr = 1'b0;
    tick();
  endtask
  // send a frame and report whether a frame event shows up
  task automatic frame(input int n, input logic [7:0] b0, b1, b2, b3,
                       output logic got);
    serial_line_model_inst.frame_mem[0] = b0;
    serial_line_model_inst.frame_mem[1] = b1;
    serial_line_model_inst.frame_mem[2] = b2;
    serial_line_model_inst.frame_mem[3] = b3;
    serial_line_model_inst.send_frame(n, 1'b1);
    got = 1'b0;
    ack_got = 1'b0;
    repeat (6) begin
      if (evt === 1'b1) got = 1'b1;
      if (ack === 1'b1) ack_got = 1'b1;
      tick();
    end
  endtask
  // run the pin clock and count receive and transmit ticks meanwhile
  task automatic count_ticks(input int p, output int nr, output int nt);
    nr = 0;
    nt = 0;
    fork
      serial_line_model_inst.run_clock(p);
      repeat (8 * p + 12) begin
        tick();
        if (rtick === 1'b1) nr++;
        if (ttick === 1'b1) nt++;
      end
    join
  endtask
  task automatic pop(input logic [7:0] exp);
    buf_rd = 1'b1;
    tick();
    buf_rd = 1'b0;
    check("buffer byte", buf_data, exp);
    tick();
  endtask
  task automatic t_power();
    check("osc enable", {7'h0, seen}, 8'h00);
    check("power-down flag", {7'h0, chst[4]}, 8'h01);
    command(3'h2);
    repeat (3) tick();
    check("osc enable", {7'h0, seen}, 8'h01);
  endtask
  task automatic t_nonauto();
    logic g;
    mode = MODE_NONAUTO;
    frame(4, 8'hfc, 8'h21, 8'h00, 8'ha1, g);
    check("frame event", {7'h0, g}, 8'h01);
    check("frames held", {6'h0, chst[1:0]}, 8'h01);
    check("crc flag", {7'h0, fst[0]}, 8'h01);
    check("frame flag", {7'h0, prim[3]}, 8'h01);
    pop(8'ha1);
    command(3'h1);
    tick();
    check("frames held", {6'h0, chst[1:0]}, 8'h00);
  endtask
  task automatic t_miss();
    logic g;
    frame(4, 8'hfe, 8'h77, 8'h00, 8'h55, g);
    check("miss event", {7'h0, g}, 8'h00);
    check("frames held", {6'h0, chst[1:0]}, 8'h00);
  endtask
  task automatic t_transp();
    logic g;
    mode = MODE_TRANSP;
    frame(4, 8'hfe, 8'h5a, 8'h13, 8'h77, g);
    check("transparent event", {7'h0, g}, 8'h01);
    check("low address", alow, 8'h5a);
    check("control field", ctrl, 8'h13);
    pop(8'h77);
    command(3'h1);
  endtask
  task automatic t_ext0();
    logic g;
    mode = MODE_EXT0;
    frame(3, 8'h11, 8'h22, 8'h33, 8'h00, g);
    check("ext0 event", {7'h0, g}, 8'h01);
    check("first byte", alow, 8'h11);
    check("second byte", ctrl, 8'h22);
    pop(8'h11);
    pop(8'h22);
    pop(8'h33);
    command(3'h1);
  endtask
  task automatic t_onebyte();
    logic g;
    mode = MODE_NONAUTO;
    addr2 = 1'b0;
    hc1 = 8'h00; // high compare cleared for one-byte use
    frame(3, 8'h43, 8'h00, 8'h44, 8'h00, g);
    check("one-byte event", {7'h0, g}, 8'h01);
    check("response flag", {7'h0, fst[1]}, 8'h01);
    pop(8'h44);
    command(3'h1);
    mode = MODE_TRANSP;
    frame(3, 8'h99, 8'h05, 8'h66, 8'h00, g);
    check("transparent one-byte event", {7'h0, g}, 8'h01);
    pop(8'h66);
    command(3'h1);
    addr2 = 1'b1;
    hc1 = 8'h10;
  endtask
  task automatic t_auto();
    logic g;
    mode = MODE_AUTO;
    frame(4, 8'h10, 8'h21, 8'h00, 8'h55, g);
    check("own i-frame event", {7'h0, g}, 8'h01);
    check("auto acknowledge", {7'h0, ack_got}, 8'h01);
    check("receive sequence", {7'h0, chst[3]}, 8'h01);
    check("own link flag", {7'h0, fst[2]}, 8'h01);
    pop(8'h55);
    command(3'h1);
    frame(3, 8'h10, 8'h21, 8'h01, 8'h00, g);
    check("own s-frame event", {7'h0, g}, 8'h00);
    frame(4, 8'hfe, 8'h21, 8'h00, 8'h66, g);
    check("other link event", {7'h0, g}, 8'h01);
    check("other link ack", {7'h0, ack_got}, 8'h00);
    check("other link flag", {7'h0, fst[2]}, 8'h00);
    pop(8'h66);
    command(3'h1);
  endtask
  task automatic t_cr();
    logic g;
    mode = MODE_NONAUTO;
    cr_inv = 1'b1;
    frame(4, 8'h12, 8'h43, 8'h00, 8'h99, g);
    check("bit-1 masked event", {7'h0, g}, 8'h01);
    check("command flag", {7'h0, fst[1]}, 8'h00);
    pop(8'h99);
    command(3'h1);
    cr_inv = 1'b0;
  endtask
  task automatic t_ext1();
    logic g;
    int nr, nt;
    mode = MODE_EXT1;
    frame(3, 8'h30, 8'h66, 8'h77, 8'h00, g);
    check("ext1 event", {7'h0, g}, 8'h01);
    pop(8'h66);
    pop(8'h77);
    command(3'h1);
    rx_en = 1'b0;
    count_ticks(8, nr, nt);
    check("raw byte", alow, 8'hff);
    rx_en = 1'b1;
  endtask
  task automatic t_pool();
    logic g;
    mode = MODE_NONAUTO;
    pools = 0;
    for (int i = 4; i < 35; i++)
      serial_line_model_inst.frame_mem[i] = 8'(i);
    frame(35, 8'hfc, 8'h21, 8'h00, 8'h03, g);
    check("pool events", 8'(pools), 8'h01);
    check("pool flag", {7'h0, prim[4]}, 8'h01);
    pop(8'h03);
    command(3'h1);
  endtask
  task automatic t_chain();
    for (int i = 0; i < 3; i++) begin
      {prim_a, ext_a, ext_b} = 3'h1 << i;
      repeat (3) tick();
      check("chained flags", {5'h0, prim[2:0]}, 8'h01 << i);
    end
    {prim_a, ext_a, ext_b} = 3'h0;
    irq_rd = 1'b1;
    tick();
    irq_rd = 1'b0;
    repeat (2) tick();
    check("cleared flags", {3'h0, prim[4:3], 3'h0}, 8'h00);
  endtask
  task automatic t_clock();
    int nr, nt;
    count_ticks(4, nr, nt);
    check("receive ticks", 8'(nr), 8'h04);
    check("transmit ticks", 8'(nt), 8'h00);
    cmode = 3'h1;
    strb_en = 1'b1;
    count_ticks(2, nr, nt);
    check("gated rx ticks", 8'(nr), 8'h00);
    strb = 1'b1;
    count_ticks(2, nr, nt);
    check("strobed rx ticks", 8'(nr), 8'h02);
    check("shared tx ticks", 8'(nt), 8'h02);
    cmode = 3'h2;
    rxsrc = RXS_DPLL;
    count_ticks(8, nr, nt);
    check("dpll ticks", 8'(nr), 8'h02);
    rxsrc = RXS_OSC;
    count_ticks(2, nr, nt);
    check("osc ticks", 8'(nr), 8'h02);
    cmode = 3'h0;
    strb_en = 1'b0;
    rxsrc = RXS_PIN;
    command(3'h4);
    count_ticks(2, nr, nt);
    check("powered-down ticks", 8'(nr), 8'h00);
    check("osc stopped", {7'h0, seen}, 8'h00);
  endtask
  task automatic close_out();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // reset, then run the scenarios
  initial begin
    {rst_n_i, cmd_wr, irq_rd, buf_rd, ext_b, ext_a, prim_a} = 7'h0;
    {addr2, rx_en} = 2'h3;
    mode = MODE_NONAUTO;
    hc1 = 8'h10;
    hc2 = 8'h30;
    lc1 = 8'h21;
    lc2 = 8'h43;
    cmode = 3'h0;
    rxsrc = RXS_PIN;
    {cr_inv, strb_en, strb} = 3'h0;
    pools = 0;
    cmd = 3'h0;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    tick();
    t_power();
    t_nonauto();
    t_miss();
    t_transp();
    t_ext0();
    t_onebyte();
    t_auto();
    t_cr();
    t_ext1();
    t_pool();
    t_chain();
    t_clock();
    close_out();
  end
endmodule
